// >>> hdl/db_region_cursor.sv
`timescale 1ns/10ps
// walks one host region: word index, database address, wrap at length
module db_region_cursor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // region settings
  input wire logic [15:0] base,
  input wire logic [15:0] length,
  // control
  input wire logic step,
  // position
  output logic [15:0] index,
  output logic [15:0] db_addr,
  output logic wrap
);
  logic last;

  assign last = (length == 16'h0000) || (index >= length - 16'h0001);
  assign wrap = step && last;
  assign db_addr = base + index;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index <= 16'h0000;
    end else if (step) begin
      index <= last ? 16'h0000 : index + 16'h0001;
    end
  end
endmodule : db_region_cursor

// >>> hdl/modbus_db_map.svh
`ifndef MODBUS_DB_MAP_SVH
`define MODBUS_DB_MAP_SVH
// -------------------------------------------------------------
// database geometry
// -------------------------------------------------------------
`define DB_WORDS 16'h1388
`define DB_BITS 17'h13880
`define PAGE_WORDS 16'h00C8
// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define OFS_WR_BASE 8'h00
`define OFS_WR_LEN 8'h04
`define OFS_RD_BASE 8'h08
`define OFS_RD_LEN 8'h0C
`define OFS_FAIL_LIM 8'h10
`define OFS_STAT_LOC 8'h14
`define OFS_IRQ_STAT 8'h18
`define OFS_IRQ_MASK 8'h1C
`define OFS_STATE 8'h20
// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define RST_WR_BASE 16'h0000
`define RST_WR_LEN 16'h0258
`define RST_RD_BASE 16'h03E8
`define RST_RD_LEN 16'h0258
`define RST_FAIL_LIM 16'h0000
`define RST_STAT_LOC 16'hFFFF
`define STAT_LOC_OFF 16'hFFFF
// -------------------------------------------------------------
// interrupt fields and exception codes
// -------------------------------------------------------------
`define IRQ_WR_PAGE 0
`define IRQ_RD_PAGE 1
`define IRQ_MB_EXC 2
`define IRQ_HALT 3
`define EXC_ILLEGAL_FUNC 8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`endif

// >>> hdl/modbus_db_pkg.sv
package modbus_db_pkg;
  typedef enum logic [1:0] {
    SPACE_COIL = 2'b00,
    SPACE_DISCRETE = 2'b01,
    SPACE_INPUT = 2'b10,
    SPACE_HOLDING = 2'b11
  } mb_space_t;

  typedef struct packed {
    logic valid;
    mb_space_t space;
    logic write;
    logic [16:0] addr;
    logic [15:0] wdata;
  } mb_req_t;

  typedef struct packed {
    logic valid;
    logic exception;
    logic [7:0] code;
    logic [15:0] data;
  } mb_rsp_t;
endpackage : modbus_db_pkg

// >>> hdl/modbus_slave_database_map.sv
`timescale 1ns/10ps
`include "modbus_db_map.svh"
module modbus_slave_database_map (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // host to module stream
  input wire logic host_to_module_valid,
  input wire logic [15:0] host_to_module_words,
  // module to host stream
  input wire logic module_to_host_ready,
  output logic module_to_host_valid,
  output logic [15:0] module_to_host_words,
  // backplane transfer results
  input wire logic bp_xfer_ok,
  input wire logic bp_xfer_fail,
  // modbus request and answer
  input wire modbus_db_pkg::mb_req_t mb_req,
  output modbus_db_pkg::mb_rsp_t mb_rsp,
  output logic modbus_halted
);
  // -------------------------------------------------------------
  // settings and state
  // -------------------------------------------------------------
  logic [15:0] db [0:4999];
  logic [15:0] host_write_region_base;
  logic [15:0] host_write_region_length;
  logic [15:0] host_read_region_base;
  logic [15:0] host_read_region_length;
  logic [15:0] backplane_fail_limit;
  logic [15:0] status_block_location;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [15:0] fail_count;
  logic [15:0] exc_count;
  logic stat_sel;
  logic apb_wr;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // -------------------------------------------------------------
  // apb slave
  // -------------------------------------------------------------
  assign apb_wr = psel && penable && pready && pwrite;

  always_comb begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `OFS_WR_BASE: next_prdata = {16'h0000, host_write_region_base};
      `OFS_WR_LEN: next_prdata = {16'h0000, host_write_region_length};
      `OFS_RD_BASE: next_prdata = {16'h0000, host_read_region_base};
      `OFS_RD_LEN: next_prdata = {16'h0000, host_read_region_length};
      `OFS_FAIL_LIM: next_prdata = {16'h0000, backplane_fail_limit};
      `OFS_STAT_LOC: next_prdata = {16'h0000, status_block_location};
      `OFS_IRQ_STAT: next_prdata = {28'h0000000, irq_stat};
      `OFS_IRQ_MASK: next_prdata = {28'h0000000, irq_mask};
      `OFS_STATE: next_prdata = {15'h0000, modbus_halted, fail_count};
      default: next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h00000000;
      pslverr <= psel && !penable && next_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_write_region_base <= `RST_WR_BASE;
      host_write_region_length <= `RST_WR_LEN;
      host_read_region_base <= `RST_RD_BASE;
      host_read_region_length <= `RST_RD_LEN;
      backplane_fail_limit <= `RST_FAIL_LIM;
      status_block_location <= `RST_STAT_LOC;
      irq_mask <= 4'h0;
    end else if (apb_wr) begin
      case (paddr)
        `OFS_WR_BASE: host_write_region_base <= pwdata[15:0];
        `OFS_WR_LEN: host_write_region_length <= pwdata[15:0];
        `OFS_RD_BASE: host_read_region_base <= pwdata[15:0];
        `OFS_RD_LEN: host_read_region_length <= pwdata[15:0];
        `OFS_FAIL_LIM: backplane_fail_limit <= pwdata[15:0];
        `OFS_STAT_LOC: status_block_location <= pwdata[15:0];
        `OFS_IRQ_MASK: irq_mask <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------
  // host region cursors
  // -------------------------------------------------------------
  logic [15:0] wr_index;
  logic [15:0] wr_addr;
  logic wr_wrap;
  logic hw_we;
  logic [15:0] rd_index;
  logic [15:0] rd_addr;
  logic rd_wrap;
  logic rd_load;

  db_region_cursor u_write_cursor (
    .pclk(pclk),
    .presetn(presetn),
    .base(host_write_region_base),
    .length(host_write_region_length),
    .step(host_to_module_valid),
    .index(wr_index),
    .db_addr(wr_addr),
    .wrap(wr_wrap)
  );

  db_region_cursor u_read_cursor (
    .pclk(pclk),
    .presetn(presetn),
    .base(host_read_region_base),
    .length(host_read_region_length),
    .step(rd_load),
    .index(rd_index),
    .db_addr(rd_addr),
    .wrap(rd_wrap)
  );

  assign hw_we = host_to_module_valid && (wr_addr < `DB_WORDS);
  assign rd_load = !module_to_host_valid || module_to_host_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_to_host_valid <= 1'b0;
      module_to_host_words <= 16'h0000;
    end else if (rd_load) begin
      module_to_host_valid <= 1'b1;
      module_to_host_words <= (rd_addr < `DB_WORDS) ? db[rd_addr[12:0]] : 16'h0000;
    end
  end

  // -------------------------------------------------------------
  // modbus address decode
  // -------------------------------------------------------------
  logic bit_space;
  logic writable;
  logic in_range;
  logic mb_accept;
  logic mb_we;
  logic [12:0] mb_word;
  logic [3:0] mb_bit;

  assign bit_space = (mb_req.space == modbus_db_pkg::SPACE_COIL) ||
                     (mb_req.space == modbus_db_pkg::SPACE_DISCRETE);
  assign writable = (mb_req.space == modbus_db_pkg::SPACE_COIL) ||
                    (mb_req.space == modbus_db_pkg::SPACE_HOLDING);
  assign in_range = bit_space ? (mb_req.addr < `DB_BITS) :
                    (mb_req.addr < {1'b0, `DB_WORDS});
  assign mb_word = bit_space ? mb_req.addr[16:4] : mb_req.addr[12:0];
  assign mb_bit = mb_req.addr[3:0];
  assign mb_accept = mb_req.valid && !modbus_halted;
  assign mb_we = mb_accept && mb_req.write && in_range && writable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mb_rsp <= '0;
    end else begin
      mb_rsp.valid <= mb_accept;
      mb_rsp.exception <= mb_accept && (!in_range || (mb_req.write && !writable));
      mb_rsp.code <= !in_range ? `EXC_ILLEGAL_ADDR :
                     (mb_req.write && !writable) ? `EXC_ILLEGAL_FUNC : 8'h00;
      if (!in_range || mb_req.write) begin
        mb_rsp.data <= mb_req.wdata;
      end else if (bit_space) begin
        mb_rsp.data <= {15'h0000, db[mb_word][mb_bit]};
      end else begin
        mb_rsp.data <= db[mb_word];
      end
    end
  end

  // -------------------------------------------------------------
  // database writes, host wins a same-word clash
  // -------------------------------------------------------------
  logic st_we;
  logic [15:0] st_addr;
  logic [15:0] st_word;

  assign st_addr = status_block_location + {15'h0000, stat_sel};
  assign st_word = stat_sel ? exc_count : {modbus_halted, fail_count[14:0]};
  assign st_we = (status_block_location != `STAT_LOC_OFF) && (st_addr < `DB_WORDS) &&
                 !mb_we && !hw_we;

  always_ff @(posedge pclk) begin
    if (st_we) begin
      db[st_addr[12:0]] <= st_word;
    end
    if (mb_we && bit_space) begin
      db[mb_word][mb_bit] <= mb_req.wdata[0];
    end else if (mb_we) begin
      db[mb_word] <= mb_req.wdata;
    end
    if (hw_we) begin
      db[wr_addr[12:0]] <= host_to_module_words;
    end
  end

  // -------------------------------------------------------------
  // backplane failures and status counters
  // -------------------------------------------------------------
  logic [15:0] next_fail_count;

  assign next_fail_count = bp_xfer_ok ? 16'h0000 :
                           (bp_xfer_fail && fail_count != 16'hFFFF) ? fail_count + 16'h0001 :
                           fail_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_count <= 16'h0000;
      modbus_halted <= 1'b0;
      exc_count <= 16'h0000;
      stat_sel <= 1'b0;
    end else begin
      fail_count <= next_fail_count;
      modbus_halted <= (backplane_fail_limit != 16'h0000) &&
                       (next_fail_count >= backplane_fail_limit);
      if (mb_accept && (!in_range || (mb_req.write && !writable))) begin
        exc_count <= exc_count + 16'h0001;
      end
      if (st_we) begin
        stat_sel <= !stat_sel;
      end
    end
  end

  // -------------------------------------------------------------
  // interrupts, set wins over clear
  // -------------------------------------------------------------
  logic [3:0] irq_set;
  logic [3:0] irq_clr;

  assign irq_set = {!modbus_halted && (backplane_fail_limit != 16'h0000) &&
                    (next_fail_count >= backplane_fail_limit),
                    mb_accept && (!in_range || (mb_req.write && !writable)),
                    rd_wrap, wr_wrap};
  assign irq_clr = (apb_wr && paddr == `OFS_IRQ_STAT) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_range_exception: assert property (
    mb_req.valid && !modbus_halted && !in_range |=>
      mb_rsp.valid && mb_rsp.exception && mb_rsp.code == 8'h02)
    else $error("out-of-range request not answered with address exception");

  chk_reject_no_write: assert property (
    mb_req.valid && !in_range |-> !mb_we)
    else $error("out-of-range request wrote the database");

  chk_halt_at_limit: assert property (
    backplane_fail_limit != 16'h0000 && bp_xfer_fail && !bp_xfer_ok &&
    fail_count + 16'h0001 == backplane_fail_limit |=> modbus_halted)
    else $error("modbus not halted at failure limit");

  chk_halt_blocks: assert property (
    modbus_halted && mb_req.valid |=> !mb_rsp.valid)
    else $error("halted device answered a request");

  chk_write_base: assert property (
    host_to_module_valid && wr_index == 16'h0000 |-> wr_addr == host_write_region_base)
    else $error("first host word not at write base");

  chk_read_base: assert property (
    rd_load && rd_index == 16'h0000 |-> rd_addr == host_read_region_base)
    else $error("first host-read word not from read base");

  chk_holding_word: assert property (
    mb_req.valid && !modbus_halted && !mb_req.write && in_range && !bit_space |=>
      mb_rsp.data == $past(db[mb_word]))
    else $error("register read returned wrong word");

  chk_coil_bit: assert property (
    mb_req.valid && !modbus_halted && !mb_req.write && in_range && bit_space |=>
      mb_rsp.data == {15'h0000, $past(db[mb_word][mb_bit])})
    else $error("bit read returned wrong bit");

  chk_status_slot: assert property (
    st_we |-> st_addr >= status_block_location && st_addr <= status_block_location + 16'h0001)
    else $error("status written outside its block");

  chk_irq_level: assert property (
    $rose(irq) |-> |(irq_stat & irq_mask))
    else $error("interrupt raised with no unmasked status");

  cov_write_wrap: cover property (wr_wrap);
  cov_read_wrap: cover property (rd_wrap && module_to_host_ready);
  cov_exception: cover property (mb_rsp.valid && mb_rsp.exception);
  cov_halt: cover property ($rose(modbus_halted));
endmodule : modbus_slave_database_map

// >>> tb/mb_master_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// modbus master: one request at a time
// ---------------------------------------------
module mb_master_model (
  // clock
  input wire logic pclk,
  // request and answer
  output modbus_db_pkg::mb_req_t mb_req,
  input wire modbus_db_pkg::mb_rsp_t mb_rsp
);
  initial begin
    mb_req = '0;
  end

  task automatic xfer(input logic [1:0] sp, input logic wr, input logic [16:0] ad,
    input logic [15:0] wd, output modbus_db_pkg::mb_rsp_t rsp);
    @(posedge pclk);
    mb_req <= {1'b1, sp, wr, ad, wd};
    @(posedge pclk);
    // released fields show the inverse, not the stale request
    mb_req <= {1'b0, ~sp, ~wr, ~ad, ~wd};
    // answer stands in the cycle after the request edge: take it at the next edge
    @(posedge pclk);
    rsp = mb_rsp;
  endtask : xfer
endmodule : mb_master_model

// >>> tb/test_modbus_slave_database_map.sv
`timescale 1ns/10ps
module test_modbus_slave_database_map;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic hv, mr, mv, bp_ok, bp_fail, halted, err;
  logic [15:0] hw, mw;
  modbus_db_pkg::mb_req_t mb_req;
  modbus_db_pkg::mb_rsp_t mb_rsp, rsp;
  int error_cnt, compares;

  modbus_slave_database_map i_modbus_slave_database_map (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .host_to_module_valid(hv), .host_to_module_words(hw),
    .module_to_host_ready(mr), .module_to_host_valid(mv), .module_to_host_words(mw),
    .bp_xfer_ok(bp_ok), .bp_xfer_fail(bp_fail), .mb_req(mb_req), .mb_rsp(mb_rsp),
    .modbus_halted(halted)
  );
  mb_master_model i_mb_master_model (.pclk(pclk), .mb_req(mb_req), .mb_rsp(mb_rsp));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ---------------------------------------------
  // bus, backplane pulse, compare and closing tasks
  // ---------------------------------------------
  task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_v

  task automatic chk_b(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask : chk_b

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] pready exp 1 got %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic mb(input logic [1:0] sp, input logic w, input logic [16:0] a,
    input logic [15:0] d);
    i_mb_master_model.xfer(sp, w, a, d, rsp);
  endtask : mb

  task automatic pulse(input logic f);
    @(posedge pclk);
    bp_fail <= f;
    bp_ok <= ~f;
    @(posedge pclk);
    bp_fail <= 1'b0;
    bp_ok <= 1'b0;
  endtask : pulse

  task automatic wrap_up;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs;
    logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] e[6] = '{32'h0, 32'h258, 32'h3E8, 32'h258, 32'h0, 32'hFFFF};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk_v("setting", e[i], rd);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk_b("unmapped err", 1'b1, err);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_host_write;
    apb(1'b1, 8'h04, 32'h258);
    for (int i = 0; i < 600; i++) begin
      @(posedge pclk);
      hv <= 1'b1;
      hw <= 16'(i) ^ 16'h5A00;
    end
    @(posedge pclk);
    hv <= 1'b0;
    mb(2'b11, 1'b0, 17'd0, 16'h0);
    chk_v("hold 0", 32'h5A00, 32'(rsp.data));
    mb(2'b11, 1'b0, 17'd599, 16'h0);
    chk_v("hold 599", 32'h5A00 ^ 32'd599, 32'(rsp.data));
    mb(2'b10, 1'b0, 17'd599, 16'h0);
    chk_v("input 599", 32'h5A00 ^ 32'd599, 32'(rsp.data));
    mb(2'b00, 1'b0, 17'd49, 16'h0);
    chk_b("coil 3.1", 1'b1, rsp.data[0]);
    mb(2'b01, 1'b0, 17'd50, 16'h0);
    chk_b("discrete 3.2", 1'b0, rsp.data[0]);
    apb(1'b1, 8'h1C, 32'h1);
    repeat (2) @(posedge pclk);
    chk_b("irq wrap", 1'b1, irq);
    apb(1'b0, 8'h18, 32'h0);
    chk_v("irq status", 32'h1, rd);
    apb(1'b1, 8'h18, 32'h1);
    repeat (2) @(posedge pclk);
    chk_b("irq cleared", 1'b0, irq);
    apb(1'b1, 8'h00, 32'h7D0);
    @(posedge pclk);
    hv <= 1'b1;
    hw <= 16'hBEEF;
    @(posedge pclk);
    hv <= 1'b0;
    mb(2'b11, 1'b0, 17'd2000, 16'h0);
    chk_v("moved base", 32'hBEEF, 32'(rsp.data));
    $display("t_host_write done");
  endtask : t_host_write

  task automatic t_host_read;
    apb(1'b1, 8'h0C, 32'h258);
    mb(2'b11, 1'b1, 17'd1000, 16'h1111);
    mb(2'b11, 1'b1, 17'd1001, 16'h2222);
    mb(2'b11, 1'b1, 17'd1002, 16'h0000);
    mb(2'b00, 1'b1, 17'd16047, 16'h0001);
    // mid-run reset: database kept, read cursor restarts at the read base
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk_b("reset valid", 1'b0, mv);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk_b("read valid", 1'b1, mv);
    chk_v("read word 0", 32'h1111, 32'(mw));
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      mr <= 1'b1;
      @(posedge pclk);
      mr <= 1'b0;
      #1;
      chk_v("read next", i == 0 ? 32'h2222 : 32'h8000, 32'(mw));
    end
    $display("t_host_read done");
  endtask : t_host_read

  task automatic t_range;
    mb(2'b11, 1'b0, 17'd4999, 16'h0);
    chk_b("last reg ok", 1'b0, rsp.exception);
    mb(2'b11, 1'b0, 17'd5000, 16'h0);
    chk_v("reg range", 32'h102, {23'h0, rsp.exception, rsp.code});
    mb(2'b00, 1'b1, 17'h13880, 16'h1);
    chk_v("coil range", 32'h102, {23'h0, rsp.exception, rsp.code});
    mb(2'b01, 1'b1, 17'd5, 16'h1);
    chk_v("discrete write", 32'h101, {23'h0, rsp.exception, rsp.code});
    $display("t_range done");
  endtask : t_range

  task automatic t_halt;
    apb(1'b1, 8'h10, 32'h2);
    pulse(1'b1);
    repeat (2) @(posedge pclk);
    chk_b("one fail", 1'b0, halted);
    pulse(1'b1);
    repeat (2) @(posedge pclk);
    chk_b("halted", 1'b1, halted);
    apb(1'b0, 8'h20, 32'h0);
    chk_v("state", 32'h00010002, rd);
    mb(2'b11, 1'b0, 17'd0, 16'h0);
    chk_b("silent", 1'b0, rsp.valid);
    pulse(1'b0);
    repeat (2) @(posedge pclk);
    chk_b("resumed", 1'b0, halted);
    mb(2'b11, 1'b0, 17'd0, 16'h0);
    chk_b("answers", 1'b1, rsp.valid);
    $display("t_halt done");
  endtask : t_halt

  task automatic t_status;
    apb(1'b1, 8'h14, 32'hFA0);
    pulse(1'b1);
    repeat (10) @(posedge pclk);
    mb(2'b11, 1'b0, 17'd4000, 16'h0);
    chk_v("status word", 32'h1, 32'(rsp.data));
    mb(2'b11, 1'b0, 17'd4001, 16'h0);
    chk_v("status exceptions", 32'h3, 32'(rsp.data));
    $display("t_status done");
  endtask : t_status

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, hv, mr, bp_ok, bp_fail} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hw = 16'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_host_write();
    t_host_read();
    t_range();
    t_halt();
    t_status();
    wrap_up();
  end

  initial begin
    #50000;
    error_cnt++;
    wrap_up();
  end
endmodule : test_modbus_slave_database_map
